// ### dv/aem_checker.sv
// Purpose: port level checks on the encoder offset map
// Assumes: parameter inputs change only together with a load
// Notes: readings are checked only with i_ce held high
module aem_checker (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // stimulus
  input wire aem_pkg::aem_step_t i_enc_pos,
  input wire logic i_enc_vld,
  input wire logic i_param_load,
  input wire aem_pkg::aem_step_t i_enc_total_steps,
  input wire aem_pkg::aem_step_t i_enc_offset,
  input wire aem_pkg::aem_coord_t i_ref_coord,
  input wire aem_pkg::aem_coord_t i_working_range_start_limit,
  input wire aem_pkg::aem_coord_t i_working_range_end_limit,
  input wire aem_pkg::aem_res_t i_resolution,
  input wire logic i_set_ref,
  // results
  input wire aem_pkg::aem_pos_t o_position,
  input wire aem_pkg::aem_coord_t o_coord,
  input wire logic o_pos_vld,
  input wire logic o_synced,
  input wire logic o_param_err,
  input wire aem_pkg::aem_coord_t o_range_min,
  input wire aem_pkg::aem_coord_t o_range_max,
  input wire aem_pkg::aem_step_t o_svc_offset,
  input wire logic o_svc_offset_vld
);
  import aem_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////
  wire aem_coord_t st = i_working_range_start_limit;
  wire aem_coord_t en = i_working_range_end_limit;
  wire logic signed [33:0] tot = {9'h000, i_enc_total_steps};
  wire logic signed [33:0] span = en - st + 34'sh1;
  wire logic cfg_ok = st < en && i_ref_coord >= st && i_ref_coord <= en &&
    i_enc_offset < i_enc_total_steps && span <= tot && tot != 0 &&
    i_resolution != 0;
  // the reading at set-reference pairs with the reference coordinate
  wire aem_step_t exp_off = i_enc_pos;

  sequence s_take(logic hit);
    i_ce && i_enc_vld && o_synced && !i_param_load && !i_set_ref &&
    !o_svc_offset_vld && i_enc_pos < i_enc_total_steps && hit
    ##1 i_ce && !i_param_load;
  endsequence

  AST_OFFSET_REFUSED: assert property (i_ce && i_param_load &&
    i_enc_offset >= i_enc_total_steps |=> o_param_err && !o_synced)
    else $error("offset beyond total accepted");
  AST_LOAD_RESULT: assert property (i_ce && i_param_load |=>
    o_synced == $past(cfg_ok) && o_param_err == !$past(cfg_ok))
    else $error("load verdict wrong");
  AST_REF_PAIR: assert property (s_take(i_enc_pos == i_enc_offset)
    |=> o_pos_vld && o_coord == i_ref_coord)
    else $error("offset reading not at reference");
  AST_SET_REF: assert property (i_ce && i_set_ref && i_enc_vld &&
    i_enc_pos < i_enc_total_steps && !i_param_load && o_synced &&
    !o_param_err |=> o_svc_offset_vld && o_synced &&
    o_svc_offset == $past(exp_off))
    else $error("set reference offset wrong");
  AST_BOOT_SYNC: assert property (!$past(i_rst_n) && i_ce && cfg_ok
    |=> o_synced)
    else $error("not synced at start");
  AST_RANGE_SYM: assert property (o_synced |->
    o_range_max - o_range_min == i_enc_total_steps - 1 &&
    (o_range_max - en) - (st - o_range_min) inside {0, 1})
    else $error("extended range not symmetric");
  AST_ZERO_PAIR: assert property (s_take(i_enc_pos == 0 &&
    i_enc_offset == 0) |=> o_pos_vld && o_coord == i_ref_coord)
    else $error("zero reading misplaced");
  AST_POS_SCALE: assert property (o_pos_vld |-> o_position ==
    o_coord * $signed({16'h0000, i_resolution}))
    else $error("position not scaled");
endmodule

bind aem_top aem_checker u_chk (
  .i_ref_clk, .i_rst_n, .i_ce, .i_enc_pos, .i_enc_vld, .i_param_load,
  .i_enc_total_steps, .i_enc_offset, .i_ref_coord,
  .i_working_range_start_limit, .i_working_range_end_limit,
  .i_resolution, .i_set_ref, .o_position, .o_coord, .o_pos_vld,
  .o_synced, .o_param_err, .o_range_min, .o_range_max, .o_svc_offset,
  .o_svc_offset_vld
);

// ### dv/aem_enc_model.sv
// Purpose: behavioural single-turn absolute encoder
// Assumes: one reading per clock while on
// Notes: idle line toggles, so a stale reading is never mistaken
module aem_enc_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // bench control
  input wire aem_pkg::aem_step_t i_tgt,
  input wire logic i_on,
  input wire logic i_zero,
  // reading
  output aem_pkg::aem_step_t o_pos,
  output logic o_vld
);
  import aem_pkg::*;
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pos <= STEP_ZERO;
      o_vld <= 1'b0;
    end
    else
    begin
      o_vld <= i_on;
      o_pos <= !i_on ? ~o_pos : (i_zero ? STEP_ZERO : i_tgt);
    end
  end
endmodule

// ### dv/testbench.sv
// Purpose: self-checking bench for the encoder offset map
// Assumes: 2048 steps, limits -1000..1000, reference -125, scale 3
// Notes: i_ce dropped once so a reading must be frozen out
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import aem_pkg::*;
  typedef struct {aem_step_t enc; aem_coord_t crd; logic out;} aem_row_t;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic load = 1'b0, set_ref = 1'b0, on = 1'b0, zero = 1'b0, ce = 1'b1;
  logic ev, pv, outr, syn, perr, sv;
  aem_step_t tgt = 25'h000_0000, enc, soff;
  aem_step_t tot = 25'h000_0800, off = 25'h000_0000;
  aem_coord_t refc = 32'hFFFF_FF83, st = 32'hFFFF_FC18;
  aem_coord_t en = 32'h0000_03E8, crd, rmin, rmax;
  aem_res_t res = 16'h0003;
  aem_pos_t pos;
  int err_count = 0, compares = 0;
  aem_row_t rows[5] = '{'{25'h000_0000, 32'hFFFF_FF83, 1'b0},
    '{25'h000_047D, 32'h0000_0400, 1'b1}, '{25'h000_047E, 32'hFFFF_FC01, 1'b1},
    '{25'h000_07FF, 32'hFFFF_FF82, 1'b0}, '{25'h000_007D, 32'h0000_0000, 1'b0}};

  always #2 i_ref_clk = ~i_ref_clk;
  ////////////////////////////////////////////////////////////
  aem_enc_model u_enc (.i_clk(i_ref_clk), .i_rst_n, .i_tgt(tgt), .i_on(on),
    .i_zero(zero), .o_pos(enc), .o_vld(ev));
  aem_top uut (.i_ref_clk, .i_rst_n, .i_ce(ce), .i_enc_pos(enc),
    .i_enc_vld(ev), .i_param_load(load), .i_enc_total_steps(tot),
    .i_enc_offset(off), .i_ref_coord(refc),
    .i_working_range_start_limit(st), .i_working_range_end_limit(en),
    .i_resolution(res), .i_set_ref(set_ref), .o_position(pos),
    .o_coord(crd), .o_pos_vld(pv), .o_outside_range(outr), .o_synced(syn),
    .o_param_err(perr), .o_range_min(rmin), .o_range_max(rmax),
    .o_svc_offset(soff), .o_svc_offset_vld(sv));

  task automatic bad(input string n, input logic [47:0] e, s);
    err_count++;
    $display("Error %s expected %0h seen %0h", n, e, s);
  endtask
  task automatic chk_bit(input string n, input logic e, s);
    compares++;
    if (s !== e)
      bad(n, e, s);
  endtask
  task automatic chk_crd(input string n, input aem_coord_t e, s);
    compares++;
    if (s !== e)
      bad(n, e, s);
  endtask
  task automatic chk_stp(input string n, input aem_step_t e, s);
    compares++;
    if (s !== e)
      bad(n, e, s);
  endtask
  task automatic chk_pos(input string n, input aem_pos_t e, s);
    compares++;
    if (s !== e)
      bad(n, e, s);
  endtask
  // drain first so a late result of an earlier reading is not taken
  task automatic read(input aem_step_t e, output logic got);
    int n;
    repeat (6) @(posedge i_ref_clk);
    tgt <= e;
    on <= 1'b1;
    @(posedge i_ref_clk);
    on <= 1'b0;
    got = 1'b0;
    for (n = 0; n < 8 && !got; n++)
    begin
      @(posedge i_ref_clk);
      #1;
      got = (pv === 1'b1);
    end
  endtask
  // encoder idle while loading, standing in for the stopped cpu
  task automatic load_cfg(input aem_step_t o, input aem_coord_t s);
    @(posedge i_ref_clk);
    off <= o;
    st <= s;
    load <= 1'b1;
    @(posedge i_ref_clk);
    load <= 1'b0;
    @(posedge i_ref_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    logic got;
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk_bit("synced in reset", 1'b0, syn);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    chk_bit("synced at boot", 1'b1, syn);
    chk_crd("range_min", 32'hFFFF_FC01, rmin);
    chk_crd("range_max", 32'h0000_0400, rmax);
    foreach (rows[k])
    begin
      read(rows[k].enc, got);
      chk_bit("pos_vld", 1'b1, got);
      chk_crd("coord", rows[k].crd, crd);
      chk_pos("position", 48'(rows[k].crd) * 3, pos);
      chk_bit("outside", rows[k].out, outr);
    end
    @(posedge i_ref_clk);
    tgt <= 25'h000_0706;
    on <= 1'b1;
    @(posedge i_ref_clk);
    set_ref <= 1'b1;
    @(posedge i_ref_clk);
    set_ref <= 1'b0;
    on <= 1'b0;
    #1;
    chk_stp("svc_offset", 25'h000_0706, soff);
    chk_bit("svc_vld", 1'b1, sv);
    read(25'h000_0706, got);
    chk_crd("coord after set", 32'hFFFF_FF83, crd);
    load_cfg(25'h000_0706, st);
    chk_bit("svc_vld cleared", 1'b0, sv);
    read(25'h000_0706, got);
    chk_crd("coord stored offset", 32'hFFFF_FF83, crd);
    load_cfg(25'h000_0800, st);
    chk_bit("offset refused", 1'b1, perr);
    read(25'h000_0288, got);
    chk_bit("no pos unsynced", 1'b0, got);
    load_cfg(25'h000_0000, en);
    chk_bit("limits refused", 1'b1, perr);
    load_cfg(25'h000_0000, 32'hFFFF_FC18);
    chk_bit("synced again", 1'b1, syn);
    @(posedge i_ref_clk);
    zero <= 1'b1;
    read(25'h000_07FF, got);
    chk_crd("zeroed encoder", 32'hFFFF_FF83, crd);
    @(posedge i_ref_clk);
    zero <= 1'b0;
    ce <= 1'b0;
    read(25'h000_007D, got);
    chk_bit("frozen no pos", 1'b0, got);
    chk_crd("frozen coord", 32'hFFFF_FF83, crd);
    chk_bit("frozen synced", 1'b1, syn);
    @(posedge i_ref_clk);
    ce <= 1'b1;
    i_rst_n <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk_bit("synced mid reset", 1'b0, syn);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(posedge i_ref_clk);
    #1;
    chk_bit("synced reboot", 1'b1, syn);
    report_and_stop();
  end

  // about forty times the expected run
  initial
  begin
    repeat (5000) @(posedge i_ref_clk);
    err_count++;
    report_and_stop();
  end
endmodule

// ### hdl/aem_map_if.sv
// Purpose: carries active map parameters and results between control and mapper
// Assumes: single clock domain
// Notes: ctrl side drives parameters, mapper side drives results
interface aem_map_if;
  import aem_pkg::*;
  logic ce;
  logic enc_vld;
  aem_step_t enc;
  aem_step_t offset;
  aem_step_t ref_idx;
  aem_step_t total;
  aem_coord_t min_coord;
  aem_coord_t start_lim;
  aem_coord_t end_lim;
  aem_res_t res;
  logic run;
  aem_pos_t pos_r;
  aem_coord_t coord_r;
  logic pos_vld_r;
  logic outside_r;
  modport ctrl (output ce, enc_vld, enc, offset, ref_idx, total, min_coord,
                start_lim, end_lim, res, run,
                input pos_r, coord_r, pos_vld_r, outside_r);
  modport mapper (input ce, enc_vld, enc, offset, ref_idx, total, min_coord,
                  start_lim, end_lim, res, run,
                  output pos_r, coord_r, pos_vld_r, outside_r);
endinterface

// ### hdl/aem_mapper.sv
// Purpose: two-stage map of an encoder reading onto the axis coordinate
// Assumes: enc below total whenever enc_vld is high
// Notes: latency two enabled cycles from reading to position
module aem_mapper (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // parameters in, results out
  aem_map_if.mapper mif
);
  import aem_pkg::*;

  aem_step_t idx_nxt;
  aem_step_t idx_r;
  logic idx_vld_r;
  aem_coord_t coord_nxt;
  aem_pos_t pos_nxt;
  logic outside_nxt;

  //////////////////////////////////////////////////////////////////////////
  // step index counted from the low end of the extended range
  assign idx_nxt = aem_mod_add(mif.ref_idx,
                   aem_mod_sub(mif.enc, mif.offset, mif.total),
                   mif.total);
  // min_coord already holds the lower half of the spare steps
  assign coord_nxt = mif.min_coord + aem_step2coord(idx_r);
  // widen before the product so the upper bits are not lost
  assign pos_nxt = aem_pos_t'(coord_nxt) *
                   aem_pos_t'($signed({1'b0, mif.res}));
  // outside the working range but inside the extended range
  assign outside_nxt = (coord_nxt < mif.start_lim) ||
                       (coord_nxt > mif.end_lim);

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      idx_r <= STEP_ZERO;
      idx_vld_r <= 1'b0;
    end
    else if (mif.ce)
    begin
      idx_r <= idx_nxt;
      idx_vld_r <= mif.enc_vld && mif.run;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mif.coord_r <= COORD_ZERO;
      mif.pos_r <= POS_ZERO;
      mif.pos_vld_r <= 1'b0;
      mif.outside_r <= 1'b0;
    end
    else if (mif.ce)
    begin
      mif.pos_vld_r <= idx_vld_r && mif.run;
      if (idx_vld_r)
      begin
        mif.coord_r <= coord_nxt;
        mif.pos_r <= pos_nxt;
        mif.outside_r <= outside_nxt;
      end
    end
  end
endmodule

// ### hdl/aem_pkg.sv
// Purpose: shared constants, types and helpers for the encoder offset map
// Assumes: coordinates and limits are given in encoder increments
// Notes: step values are unsigned, coordinates two's complement
package aem_pkg;
  localparam int ENC_W = 25;
  localparam int COORD_W = 32;
  localparam int RES_W = 16;
  localparam int POS_W = 48;
  localparam int PAD_W = COORD_W - ENC_W;

  typedef logic [ENC_W-1:0] aem_step_t;
  typedef logic signed [COORD_W-1:0] aem_coord_t;
  typedef logic signed [POS_W-1:0] aem_pos_t;
  typedef logic [RES_W-1:0] aem_res_t;

  // reset values of the held parameters and mapper results, plus COORD_ONE for range arithmetic
  localparam aem_step_t STEP_ZERO = 25'h000_0000;
  localparam aem_step_t TOTAL_RST = 25'h000_0800;
  localparam aem_res_t RES_RST = 16'h0001;
  localparam aem_coord_t COORD_ZERO = 32'h0000_0000;
  localparam aem_coord_t COORD_ONE = 32'h0000_0001;
  localparam aem_pos_t POS_ZERO = 48'h0000_0000_0000;

  function automatic aem_coord_t aem_step2coord(input aem_step_t s);
    return aem_coord_t'({{PAD_W{1'b0}}, s});
  endfunction

  // (a + b) mod n, both operands already below n
  function automatic aem_step_t aem_mod_add(input aem_step_t a,
                                            input aem_step_t b,
                                            input aem_step_t n);
    logic [ENC_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, n})
    begin
      s = s - {1'b0, n};
    end
    return s[ENC_W-1:0];
  endfunction

  // (a - b) mod n, both operands already below n
  function automatic aem_step_t aem_mod_sub(input aem_step_t a,
                                            input aem_step_t b,
                                            input aem_step_t n);
    logic [ENC_W:0] s;
    if (a >= b)
    begin
      s = {1'b0, a} - {1'b0, b};
    end
    else
    begin
      s = {1'b0, a} + {1'b0, n} - {1'b0, b};
    end
    return s[ENC_W-1:0];
  endfunction
endpackage

// ### hdl/aem_top.sv
// Purpose: absolute encoder offset map with set-reference-point support
// Assumes: limits and reference coordinate are in encoder increments
// Notes: parameters are sampled only at start-up and on a load strobe
//
// Function
// - encoder offset must lie in 0..total-1
// - working range bounded by limits, reference inside
// - offset reading maps onto reference coordinate
// - set-reference computes offset, shown as service data
// - valid offset means synchronized right at start-up
// - spare steps extend range symmetrically around limits
// - zeroed encoder with zero offset maps correctly
module aem_top (
  // clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // encoder reading
  input wire aem_pkg::aem_step_t i_enc_pos,
  input wire logic i_enc_vld,
  // parameter set
  input wire logic i_param_load,
  input wire aem_pkg::aem_step_t i_enc_total_steps,
  input wire aem_pkg::aem_step_t i_enc_offset,
  input wire aem_pkg::aem_coord_t i_ref_coord,
  input wire aem_pkg::aem_coord_t i_working_range_start_limit,
  input wire aem_pkg::aem_coord_t i_working_range_end_limit,
  input wire aem_pkg::aem_res_t i_resolution,
  // commands
  input wire logic i_set_ref,
  // position
  output aem_pkg::aem_pos_t o_position,
  output aem_pkg::aem_coord_t o_coord,
  output logic o_pos_vld,
  output logic o_outside_range,
  // status
  output logic o_synced,
  output logic o_param_err,
  output aem_pkg::aem_coord_t o_range_min,
  output aem_pkg::aem_coord_t o_range_max,
  // service data
  output aem_pkg::aem_step_t o_svc_offset,
  output logic o_svc_offset_vld
);
  import aem_pkg::*;

  typedef enum logic [1:0] {
    AEM_ST_BOOT,
    AEM_ST_RUN
  } aem_state_t;

  aem_state_t state_r;
  aem_state_t state_nxt;
  aem_map_if mif ();

  // held parameter set
  aem_step_t total_r;
  aem_step_t offset_r;
  aem_coord_t start_r;
  aem_coord_t end_r;
  aem_coord_t min_r;
  aem_coord_t max_r;
  aem_step_t ref_idx_r;
  aem_res_t res_r;
  logic synced_r;
  logic param_err_r;
  aem_step_t svc_offset_r;
  logic svc_vld_r;

  // candidate parameter set on the inputs
  aem_coord_t span;
  aem_coord_t spare;
  aem_coord_t low_ext;
  aem_coord_t new_min;
  aem_coord_t new_max;
  aem_coord_t total_c;
  logic lim_ok;
  logic ref_ok;
  logic off_ok;
  logic span_ok;
  logic cfg_ok;
  logic do_load;
  logic do_set_ref;
  aem_step_t ref_off;

  //////////////////////////////////////////////////////////////////////////
  // range extension: spare steps split, odd step to the top end
  assign total_c = aem_step2coord(i_enc_total_steps);
  assign span = i_working_range_end_limit -
                i_working_range_start_limit + COORD_ONE;
  assign spare = total_c - span;
  assign low_ext = spare >>> 1;
  assign new_min = i_working_range_start_limit - low_ext;
  assign new_max = new_min + total_c - COORD_ONE;

  // validation of the candidate set
  assign lim_ok = i_working_range_start_limit <
                  i_working_range_end_limit;
  assign ref_ok = (i_ref_coord >= i_working_range_start_limit) &&
                  (i_ref_coord <= i_working_range_end_limit);
  assign off_ok = i_enc_offset < i_enc_total_steps;
  assign span_ok = (span <= total_c) && (i_enc_total_steps != STEP_ZERO);
  assign cfg_ok = lim_ok && ref_ok && off_ok && span_ok &&
                  (i_resolution != RES_RST - RES_RST);

  // loads only happen at start-up or on the strobe; the cpu is stopped
  assign do_load = (state_r == AEM_ST_BOOT) || i_param_load;
  // a reference set needs a sane parameter set and a fresh reading
  assign do_set_ref = (state_r == AEM_ST_RUN) && i_set_ref && !do_load &&
                      !param_err_r && i_enc_vld &&
                      (i_enc_pos < total_r);
  // the reading taken here becomes the reference's partner value,
  // matching the map, where offset pairs with the reference index
  assign ref_off = i_enc_pos;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      AEM_ST_BOOT: state_nxt = AEM_ST_RUN;
      AEM_ST_RUN: state_nxt = AEM_ST_RUN;
      default: state_nxt = AEM_ST_BOOT;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= AEM_ST_BOOT;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // parameter capture; a bad set keeps the old map but drops sync
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      total_r <= TOTAL_RST;
      offset_r <= STEP_ZERO;
      start_r <= COORD_ZERO;
      end_r <= COORD_ZERO;
      min_r <= COORD_ZERO;
      max_r <= COORD_ZERO;
      ref_idx_r <= STEP_ZERO;
      res_r <= RES_RST;
      param_err_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (do_load)
      begin
        param_err_r <= !cfg_ok;
        if (cfg_ok)
        begin
          total_r <= i_enc_total_steps;
          offset_r <= i_enc_offset;
          start_r <= i_working_range_start_limit;
          end_r <= i_working_range_end_limit;
          min_r <= new_min;
          max_r <= new_max;
          ref_idx_r <= aem_step_t'(i_ref_coord - new_min);
          res_r <= i_resolution;
        end
      end
      else if (do_set_ref)
      begin
        offset_r <= ref_off;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sync comes straight from a valid set, no seek travel needed
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      synced_r <= 1'b0;
      svc_offset_r <= STEP_ZERO;
      svc_vld_r <= 1'b0;
    end
    else if (i_ce)
    begin
      if (do_load)
      begin
        synced_r <= cfg_ok;
      end
      else if (do_set_ref)
      begin
        synced_r <= 1'b1;
      end
      if (do_set_ref)
      begin
        svc_offset_r <= ref_off;
        svc_vld_r <= 1'b1;
      end
      else if (do_load)
      begin
        svc_vld_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mapper hookup; positions flow only while synchronized
  assign mif.ce = i_ce;
  assign mif.enc_vld = i_enc_vld && (i_enc_pos < total_r);
  assign mif.enc = i_enc_pos;
  assign mif.offset = offset_r;
  assign mif.ref_idx = ref_idx_r;
  assign mif.total = total_r;
  assign mif.min_coord = min_r;
  assign mif.start_lim = start_r;
  assign mif.end_lim = end_r;
  assign mif.res = res_r;
  assign mif.run = synced_r && !do_load;

  aem_mapper u_mapper (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .mif(mif.mapper)
  );

  //////////////////////////////////////////////////////////////////////////
  assign o_position = mif.pos_r;
  assign o_coord = mif.coord_r;
  assign o_pos_vld = mif.pos_vld_r;
  assign o_outside_range = mif.outside_r;
  assign o_synced = synced_r;
  assign o_param_err = param_err_r;
  assign o_range_min = min_r;
  assign o_range_max = max_r;
  assign o_svc_offset = svc_offset_r;
  assign o_svc_offset_vld = svc_vld_r;
endmodule
